// file: cir_readback.v
// Read responder for the checksum and module identification commands.
// Assumes a serial link with 16-bit address, sampled on this clock, SCK idle low.
`timescale 1ns/1ps
`include "cir_defs.vh"
module cir_readback #(
  parameter SETTLE_CYCLES = `CIR_SETTLE_CYCLES
) (
  // Clock and reset
  input wire REF_CLK_I,
  input wire RESET_I,
  input wire SW_RESET_I,
  // Serial link from the host
  input wire SCK_I,
  input wire CS_N_I,
  input wire SDI_I,
  input wire DSI_MODE_I,
  output reg SDO_O,
  output reg SDO_OE_O,
  // Write activity on the covered registers and frame memory
  input wire WR_STB_I,
  input wire [7:0] WR_DATA_I,
  input wire WR_DONE_I,
  // Identification bytes from non-volatile storage
  input wire [7:0] IDENT_BYTE_A_I,
  input wire [7:0] IDENT_BYTE_B_I,
  input wire [7:0] IDENT_BYTE_C_I
);

  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_SEND = 3'h2;
  localparam [2:0] ST_HOLD = 3'h4;

  wire [3:0] link_sync;
  wire sck_s;
  wire cs_n_s;
  wire sdi_s;
  wire dsi_s;
  wire [7:0] first_sum_value;
  wire [7:0] running_sum_value;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg sck_d_reg;
  reg [15:0] addr_reg;
  reg [15:0] addr_next;
  reg [4:0] bit_cnt_reg;
  reg [4:0] bit_cnt_next;
  reg [15:0] shift_reg;
  reg [15:0] shift_next;
  reg [4:0] left_reg;
  reg [4:0] left_next;
  reg sdo_next;
  reg sdo_oe_next;
  reg [9:0] hit;
  reg [15:0] full_addr;

  // Link pins and the mode strap cross into this clock before use
  cir_sync #(
    .WIDTH(4),
    .RESET_VAL(4'h2)
  ) u_sync (
    .clk_i(REF_CLK_I),
    .rst_i(RESET_I),
    .async_i({DSI_MODE_I, SDI_I, CS_N_I, SCK_I}),
    .sync_o(link_sync)
  );

  assign sck_s = link_sync[0];
  assign cs_n_s = link_sync[1];
  assign sdi_s = link_sync[2];
  assign dsi_s = link_sync[3];

  cir_sum #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
  ) u_sum (
    .clk_i(REF_CLK_I),
    .rst_i(RESET_I),
    .soft_rst_i(SW_RESET_I),
    .wr_stb_i(WR_STB_I),
    .wr_data_i(WR_DATA_I),
    .wr_done_i(WR_DONE_I),
    .first_sum_value_o(first_sum_value),
    .running_sum_value_o(running_sum_value)
  );

  wire sck_rise = sck_s & ~sck_d_reg;
  wire sck_fall = ~sck_s & sck_d_reg;

  // Returns {hit, dummy wanted, byte}; display mode never gates a read
  // Bytes come in as arguments so the combinational block sees their changes
  function [9:0] cir_lookup;
    input [15:0] addr;
    input dsi;
    input [7:0] fs;
    input [7:0] rs;
    input [7:0] ia;
    input [7:0] ib;
    input [7:0] ic;
    reg ok_low;
    begin
      ok_low = (addr[7:0] == `CIR_ADDR_LOW);
      case (addr[15:8])
        `CIR_CMD_FIRST_SUM: cir_lookup = {ok_low, ~dsi, fs};
        `CIR_CMD_RUNNING_SUM: cir_lookup = {ok_low, ~dsi, rs};
        `CIR_CMD_IDENT_A: cir_lookup = {ok_low, ~dsi, ia};
        `CIR_CMD_IDENT_B: cir_lookup = {ok_low, ~dsi, ib};
        `CIR_CMD_IDENT_C: cir_lookup = {ok_low, ~dsi, ic};
        default: cir_lookup = 10'h000;
      endcase
    end
  endfunction

  always @* begin
    state_next = state_reg;
    addr_next = addr_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    left_next = left_reg;
    sdo_next = SDO_O;
    sdo_oe_next = SDO_OE_O;
    full_addr = {addr_reg[14:0], sdi_s};
    hit = cir_lookup(full_addr, dsi_s, first_sum_value, running_sum_value,
      IDENT_BYTE_A_I, IDENT_BYTE_B_I, IDENT_BYTE_C_I);
    if (cs_n_s) begin
      // Deselect ends any frame and frees the line at once
      state_next = ST_ADDR;
      bit_cnt_next = 5'h00;
      left_next = 5'h00;
      sdo_next = 1'b0;
      sdo_oe_next = 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR: begin
          if (sck_rise) begin
            addr_next = full_addr;
            bit_cnt_next = bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == 5'h0F) begin
              if (hit[9]) begin
                state_next = ST_SEND;
                if (hit[8]) begin
                  shift_next = {`CIR_DUMMY_BYTE, hit[7:0]};
                  left_next = 5'h10;
                end else begin
                  shift_next = {hit[7:0], 8'h00};
                  left_next = 5'h08;
                end
              end else begin
                state_next = ST_HOLD;
              end
            end
          end
        end
        ST_SEND: begin
          if (sck_fall) begin
            if (left_reg != 5'h00) begin
              sdo_next = shift_reg[15];
              sdo_oe_next = 1'b1;
              shift_next = {shift_reg[14:0], 1'b0};
              left_next = left_reg - 5'h01;
            end else begin
              sdo_next = 1'b0;
              sdo_oe_next = 1'b0;
              state_next = ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          // Extra clocks in the frame are ignored until deselect
          sdo_oe_next = 1'b0;
        end
        default: begin
          state_next = ST_ADDR;
          sdo_oe_next = 1'b0;
        end
      endcase
    end
  end

  always @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_reg <= ST_ADDR;
      sck_d_reg <= 1'b0;
      addr_reg <= 16'h0000;
      bit_cnt_reg <= 5'h00;
      shift_reg <= 16'h0000;
      left_reg <= 5'h00;
      SDO_O <= 1'b0;
      SDO_OE_O <= 1'b0;
    end else begin
      state_reg <= state_next;
      sck_d_reg <= sck_s;
      addr_reg <= addr_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      left_reg <= left_next;
      SDO_O <= sdo_next;
      SDO_OE_O <= sdo_oe_next;
    end
  end

endmodule

// file: cir_defs.vh
// Constants for the checksum and identification read responder.
// Assumes inclusion by the responder modules only; holds definitions and no logic.
`ifndef CIR_DEFS_VH
`define CIR_DEFS_VH

// Command codes (upper byte of the 16-bit address)
`define CIR_CMD_FIRST_SUM 8'hAA
`define CIR_CMD_RUNNING_SUM 8'hAF
`define CIR_CMD_IDENT_A 8'hDA
`define CIR_CMD_IDENT_B 8'hDB
`define CIR_CMD_IDENT_C 8'hDC
// Lower address byte every read command must carry
`define CIR_ADDR_LOW 8'h00

// Value both checksums take after any reset
`define CIR_SUM_RESET 8'h78
// Value shifted out as the leading dummy parameter
`define CIR_DUMMY_BYTE 8'h00

// Link framing
`define CIR_ADDR_BITS 16
`define CIR_BYTE_BITS 8

// Quiet time after the last write before the running sum is republished
`define CIR_SETTLE_MS 300
`define CIR_CLK_HZ 100000000
`define CIR_SETTLE_CYCLES (`CIR_SETTLE_MS * (`CIR_CLK_HZ / 1000))

`endif

// file: cir_sync.v
// Two-stage synchroniser for a vector of independent level inputs.
// Assumes each bit is a slow level or a link signal sampled well above its rate.
`timescale 1ns/1ps
module cir_sync #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Raw and synchronised levels
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_reg;

  // First stage is read by the second stage only
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end

endmodule

// file: cir_sum.v
// Checksum engine over user-area register and frame memory writes.
// Assumes a write strobe per byte and a pulse when a write access completes.
`timescale 1ns/1ps
`include "cir_defs.vh"
module cir_sum #(
  parameter SETTLE_CYCLES = `CIR_SETTLE_CYCLES,
  parameter CNT_W = 25
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  input wire soft_rst_i,
  // Write activity
  input wire wr_stb_i,
  input wire [7:0] wr_data_i,
  input wire wr_done_i,
  // Published values
  output reg [7:0] first_sum_value_o,
  output reg [7:0] running_sum_value_o
);

  localparam integer SETTLE_LAST_I = SETTLE_CYCLES - 1;
  localparam [CNT_W-1:0] SETTLE_LAST = SETTLE_LAST_I[CNT_W-1:0];

  reg [7:0] acc_reg;
  reg first_taken_reg;
  reg pending_reg;
  reg [CNT_W-1:0] quiet_cnt_reg;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_reg <= 8'h00;
      first_taken_reg <= 1'b0;
      pending_reg <= 1'b0;
      quiet_cnt_reg <= {CNT_W{1'b0}};
      first_sum_value_o <= `CIR_SUM_RESET;
      running_sum_value_o <= `CIR_SUM_RESET;
    end else if (soft_rst_i) begin
      acc_reg <= 8'h00;
      first_taken_reg <= 1'b0;
      pending_reg <= 1'b0;
      quiet_cnt_reg <= {CNT_W{1'b0}};
      first_sum_value_o <= `CIR_SUM_RESET;
      running_sum_value_o <= `CIR_SUM_RESET;
    end else begin
      // Rotate-and-xor keeps byte order significant, unlike a plain sum
      if (wr_stb_i) begin
        acc_reg <= {acc_reg[6:0], acc_reg[7]} ^ wr_data_i;
      end
      // The first sum moves only once a write access completes; the running sum after the quiet time following any strobe or completion
      if (wr_done_i && !first_taken_reg) begin
        first_sum_value_o <= acc_reg;
        first_taken_reg <= 1'b1;
      end
      if (wr_stb_i || wr_done_i) begin
        pending_reg <= 1'b1;
        quiet_cnt_reg <= {CNT_W{1'b0}};
      end else if (pending_reg) begin
        if (quiet_cnt_reg == SETTLE_LAST) begin
          running_sum_value_o <= acc_reg;
          pending_reg <= 1'b0;
        end else begin
          quiet_cnt_reg <= quiet_cnt_reg + 1'b1;
        end
      end
    end
  end

endmodule

// file: cir_readback_chk.sv
// Checker for the responder's reply framing at its ports.
// Assumes a bind to cir_readback and SCK held low outside frames.
`timescale 1ns/1ps
module cir_chk (
  // Watched ports
  input wire REF_CLK_I,
  input wire RESET_I,
  input wire SCK_I,
  input wire CS_N_I,
  input wire DSI_MODE_I,
  input wire SDO_O,
  input wire SDO_OE_O
);
  reg sck_q;
  reg [5:0] rise_cnt;
  reg [4:0] fall_cnt;
  // Raw pin edges; the responder sees them later through its synchroniser
  always @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      sck_q <= 1'b0;
      rise_cnt <= 6'h00;
      fall_cnt <= 5'h00;
    end else begin
      sck_q <= SCK_I;
      rise_cnt <= CS_N_I ? 6'h00 : rise_cnt + {5'h00, SCK_I & ~sck_q};
      fall_cnt <= SDO_OE_O ? fall_cnt + {4'h0, sck_q & ~SCK_I} : 5'h00;
    end
  end
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RESET_I);
  a_oe_after_addr: assert property ($rose(SDO_OE_O) |-> rise_cnt == 6'h10)
    else $error("reply start off");
  a_oe_in_frame: assert property ($rose(SDO_OE_O) |-> !CS_N_I && !$past(CS_N_I, 4))
    else $error("reply outside frame");
  a_idle_quiet: assert property (CS_N_I [*6] |-> !SDO_OE_O)
    else $error("reply while idle");
  a_cs_drop: assert property ($rose(CS_N_I) |-> ##[0:4] !SDO_OE_O)
    else $error("enable held");
  // A frame cut by deselect ends early, so length is judged on complete frames only
  a_serial_len: assert property ($fell(SDO_OE_O) && !CS_N_I && !DSI_MODE_I |-> fall_cnt == 5'h10)
    else $error("serial reply length");
  a_dsi_len: assert property ($fell(SDO_OE_O) && !CS_N_I && DSI_MODE_I |-> fall_cnt == 5'h08)
    else $error("dsi reply length");
  a_dummy_zero: assert property (SDO_OE_O && !DSI_MODE_I && fall_cnt < 5'h08 |-> !SDO_O)
    else $error("dummy not zero");
  a_sdo_steady: assert property ($rose(SCK_I) |-> ##1 $stable(SDO_O) [*3])
    else $error("data moved");
endmodule

// file: cir_host.sv
// Host model: one read command per frame, SCK idle low, 8 clocks a bit.
// Assumes the responder samples the link on the same clock.
`timescale 1ns/1ps
module cir_host (
  // Clock
  input wire clk_i,
  // Link
  input wire sdo_i,
  input wire sdo_oe_i,
  output reg sck_o = 1'b0,
  output reg cs_n_o = 1'b1,
  output reg sdi_o = 1'b0
);
  task xfer(input [15:0] a, input [4:0] nb, output [15:0] d, output seen);
    integer i;
    begin
      d = 16'h0000;
      seen = 1'b0;
      @(posedge clk_i) cs_n_o <= 1'b0;
      for (i = 0; i < 16 + nb; i = i + 1) begin
        @(posedge clk_i) sck_o <= 1'b0;
        // Released data toggles so a held value is never relied on
        sdi_o <= (i < 16) ? a[15 - i] : ~sdi_o;
        repeat (4) @(posedge clk_i);
        sck_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        if (i >= 16) begin
          // A released line reads back as the previous bit inverted, so a bit outside the enable shows up
          d = {d[14:0], sdo_oe_i ? sdo_i : ~d[0]};
          seen = seen | sdo_oe_i;
        end
      end
      @(posedge clk_i) sck_o <= 1'b0;
      repeat (6) @(posedge clk_i);
      cs_n_o <= 1'b1;
      sdi_o <= ~sdi_o;
      repeat (6) @(posedge clk_i);
    end
  endtask
endmodule

// file: checksum_and_id_readback_bench.sv
// Self-checking bench for the checksum and identification readback responder.
// Assumes the host model cir_host and the checker cir_chk.
`timescale 1ns/1ps
module checksum_and_id_readback_bench;
  reg clk = 1'b0, rst = 1'b1, sw_rst = 1'b0, dsi = 1'b0, stb = 1'b0, done = 1'b0;
  reg [7:0] wdat = 8'h00, acc;
  reg [7:0] ident [0:2];
  reg [15:0] cut_d;
  reg cut_s;
  wire sck, cs_n, sdi, sdo, oe;
  integer fail_count = 0, num_checks = 0, k, m;
  always #5 clk = ~clk;
  // Short quiet time keeps the run brief
  cir_readback #(.SETTLE_CYCLES(20)) u_dut (
    .REF_CLK_I(clk), .RESET_I(rst), .SW_RESET_I(sw_rst),
    .SCK_I(sck), .CS_N_I(cs_n), .SDI_I(sdi), .DSI_MODE_I(dsi), .SDO_O(sdo), .SDO_OE_O(oe),
    .WR_STB_I(stb), .WR_DATA_I(wdat), .WR_DONE_I(done),
    .IDENT_BYTE_A_I(ident[0]), .IDENT_BYTE_B_I(ident[1]), .IDENT_BYTE_C_I(ident[2])
  );
  cir_host u_host (.clk_i(clk), .sdo_i(sdo), .sdo_oe_i(oe),
    .sck_o(sck), .cs_n_o(cs_n), .sdi_o(sdi));
  task stop_test;
    begin
      if (fail_count == 0 && num_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task check(input [63:0] what, input [15:0] seen, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("unexpected %0s: expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task rd(input [15:0] a, input md, input [7:0] v, input ok);
    reg [15:0] d;
    reg s;
    begin
      @(posedge clk) dsi <= md;
      u_host.xfer(a, md ? 5'd8 : 5'd16, d, s);
      if (ok)
        check("reply", d, {8'h00, v});
      check("enable", {15'h0000, s}, {15'h0000, ok});
    end
  endtask
  task wr(input [7:0] b, input s, input dn);
    begin
      @(posedge clk) stb <= s;
      wdat <= b;
      done <= dn;
      @(posedge clk) stb <= 1'b0;
      done <= 1'b0;
    end
  endtask
  function [7:0] rotx(input [7:0] a, input [7:0] b);
    rotx = {a[6:0], a[7]} ^ b;
  endfunction
  initial begin
    #200000;
    fail_count = fail_count + 1;
    stop_test;
  end
  initial begin
    ident[0] = 8'h3C;
    ident[1] = 8'hA5;
    ident[2] = 8'h0F;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    for (m = 0; m < 2; m = m + 1) begin
      rd(16'hAA00, m[0], 8'h78, 1'b1);
      rd(16'hAF00, m[0], 8'h78, 1'b1);
      for (k = 0; k < 3; k = k + 1)
        rd({8'hDA + k[7:0], 8'h00}, m[0], ident[k], 1'b1);
      rd(16'hAA01, m[0], 8'h00, 1'b0);
      rd(16'h7D00, m[0], 8'h00, 1'b0);
    end
    acc = rotx(8'h00, 8'h12);
    wr(8'h12, 1'b1, 1'b0);
    wr(8'h00, 1'b0, 1'b1);
    // Late completion must leave the first sum alone
    wr(8'h34, 1'b1, 1'b1);
    repeat (30) @(posedge clk);
    rd(16'hAA00, 1'b0, acc, 1'b1);
    rd(16'hAF00, 1'b1, rotx(acc, 8'h34), 1'b1);
    @(posedge clk) sw_rst <= 1'b1;
    @(posedge clk) sw_rst <= 1'b0;
    rd(16'hAA00, 1'b1, 8'h78, 1'b1);
    rd(16'hAF00, 1'b0, 8'h78, 1'b1);
    wr(8'h55, 1'b1, 1'b1);
    rd(16'hAA00, 1'b0, 8'h00, 1'b1);
    // Frame cut after four reply bits: deselect must free the line mid-reply
    u_host.xfer(16'hDA00, 5'd4, cut_d, cut_s);
    check("cut", cut_d, 16'h0000);
    check("cut_oe", {15'h0000, cut_s}, 16'h0001);
    rd(16'hAF00, 1'b1, 8'h55, 1'b1);
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd(16'hAF00, 1'b1, 8'h78, 1'b1);
    rd(16'hAA00, 1'b0, 8'h78, 1'b1);
    stop_test;
  end
endmodule
bind cir_readback cir_chk u_chk (.REF_CLK_I(REF_CLK_I), .RESET_I(RESET_I), .SCK_I(SCK_I),
  .CS_N_I(CS_N_I), .DSI_MODE_I(DSI_MODE_I), .SDO_O(SDO_O), .SDO_OE_O(SDO_OE_O));
